/* File: core/drc_top.sv */
// two-channel latching-relay pulse controller
// Function
// - supply lockout holds both coil outputs off
// - enable level gates every coil pulse
// - enable changes act after 5 us filter
// - enable low clears outputs and channel state
// - lockouts override the enable
// - both channels behave identically
// - commands start only on rising edges
// - pulses not longer than qualify time ignored
// - output turns on once command qualifies
// - follow mode ends the pulse when the input falls
// - times and mode are build parameters
// - overlapping second input holds first result pending
// - both qualified go to mutual exclusion
// - unqualified second input ignored, first executes
// - two qualified commands give no pulse
// - other channel discarded during a pulse
// - every pulse ends by maximum width at the latest
// - fixed mode pulse lasts maximum width
`timescale 1ns/10ps
`default_nettype none
`include "drc_regs.svh"
module drc_top
  import drc_pkg::*;
#(
  parameter logic [`DRC_CNT_W-1:0] QUAL_TICKS = `DRC_CNT_W'(`DRC_US_TO_TICKS(`DRC_QUAL_US)),
  parameter logic [`DRC_CNT_W-1:0] MAX_TICKS  = `DRC_CNT_W'(`DRC_US_TO_TICKS(`DRC_MAX_US)),
  parameter drc_mode_type          OUT_MODE   = DRC_MODE_FOLLOW
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic coil_cmd_a,
  input  wire logic coil_cmd_b,
  input  wire logic relay_enable,
  input  wire logic supply_low_lockout,
  input  wire logic overtemp_shutdown,
  output logic      coil_drive_a_out,
  output logic      coil_drive_a_oe,
  output logic      coil_drive_b_out,
  output logic      coil_drive_b_oe
);
  logic [1:0]             sync1_ff;
  logic [1:0]             sync2_ff;
  logic [`DRC_TICK_W-1:0] tick_cnt_ff;
  logic                   tick_ff;
  logic [`DRC_EN_W-1:0]   en_cnt_ff;
  logic                   en_filt_ff;
  logic                   en_fall;
  logic                   run;
  logic [1:0]             chan_clr;
  logic [1:0]             qualifying;
  logic [1:0]             qualified;
  drc_state_type          state_ff;
  drc_state_type          nxt_state;
  logic [`DRC_CNT_W-1:0]  pulse_cnt_ff;
  logic                   pulse_end;
  logic                   drive_a_ff;
  logic                   drive_b_ff;
  logic                   low_ff;

  function automatic logic in_pulse(input drc_state_type s);
    in_pulse = (s == ST_PULSE_A) || (s == ST_PULSE_B);
  endfunction : in_pulse

  // two-stage command synchronisers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
    end else if (clk_en) begin
      sync1_ff <= {coil_cmd_b, coil_cmd_a};
      sync2_ff <= sync1_ff;
    end
  end

  // free-running timebase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= `DRC_TICK_RST;
      tick_ff     <= 1'b0;
    end else if (clk_en) begin
      tick_ff <= (tick_cnt_ff == `DRC_TICK_W'(`DRC_TICK_CYC - 1));
      if (tick_cnt_ff == `DRC_TICK_W'(`DRC_TICK_CYC - 1)) tick_cnt_ff <= `DRC_TICK_RST;
      else tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  // enable filter: a new level must stand for the whole filter time
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_cnt_ff  <= `DRC_EN_RST;
      en_filt_ff <= 1'b0;
    end else if (clk_en) begin
      if (relay_enable == en_filt_ff) en_cnt_ff <= `DRC_EN_RST;
      else if (en_cnt_ff == `DRC_EN_W'(`DRC_EN_FILT_CYC - 1)) begin
        en_cnt_ff  <= `DRC_EN_RST;
        en_filt_ff <= relay_enable;
      end else en_cnt_ff <= en_cnt_ff + 1'b1;
    end
  end

  assign en_fall = en_filt_ff && !relay_enable
                   && (en_cnt_ff == `DRC_EN_W'(`DRC_EN_FILT_CYC - 1));
  assign run = en_filt_ff && !en_fall
               && !supply_low_lockout && !overtemp_shutdown;

  // channels held in CH_WAIT_LOW while disabled, discarded during the other pulse
  assign chan_clr[0] = !run || state_ff == ST_PULSE_B || state_ff == ST_REARM;
  assign chan_clr[1] = !run || state_ff == ST_PULSE_A || state_ff == ST_REARM;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      drc_chan #(.QUAL_TICKS(QUAL_TICKS)) u_chan (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .tick      (tick_ff),
        .clr       (chan_clr[gi]),
        .cmd       (sync2_ff[gi]),
        .qualifying(qualifying[gi]),
        .qualified (qualified[gi])
      );
    end
  endgenerate

  always_comb begin
    pulse_end = tick_ff && pulse_cnt_ff == MAX_TICKS - 1'b1;
    if (OUT_MODE == DRC_MODE_FOLLOW) begin
      if (state_ff == ST_PULSE_A && !sync2_ff[0]) pulse_end = 1'b1;
      if (state_ff == ST_PULSE_B && !sync2_ff[1]) pulse_end = 1'b1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      // a qualified channel waits while the other still qualifies
      ST_IDLE: begin
        if (qualified[0] && qualified[1]) nxt_state = ST_REARM;
        else if (qualified[0] && !qualifying[1]) nxt_state = ST_PULSE_A;
        else if (qualified[1] && !qualifying[0]) nxt_state = ST_PULSE_B;
      end
      ST_PULSE_A, ST_PULSE_B: begin
        if (pulse_end) nxt_state = ST_REARM;
      end
      ST_REARM: nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
    if (!run) nxt_state = ST_IDLE;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) state_ff <= ST_IDLE;
    else if (clk_en) state_ff <= nxt_state;
  end

  // pulse width in timebase ticks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pulse_cnt_ff <= `DRC_CNT_RST;
    else if (clk_en) begin
      if (!in_pulse(state_ff)) pulse_cnt_ff <= `DRC_CNT_RST;
      else if (tick_ff) pulse_cnt_ff <= pulse_cnt_ff + 1'b1;
    end
  end

  // open-drain drivers: pull low only while pulsing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive_a_ff <= 1'b0;
      drive_b_ff <= 1'b0;
      low_ff     <= 1'b0;
    end else if (clk_en) begin
      drive_a_ff <= (nxt_state == ST_PULSE_A);
      drive_b_ff <= (nxt_state == ST_PULSE_B);
      low_ff     <= 1'b0;
    end
  end

  assign coil_drive_a_oe  = drive_a_ff;
  assign coil_drive_b_oe  = drive_b_ff;
  assign coil_drive_a_out = low_ff;
  assign coil_drive_b_out = low_ff;

  // safety and arbitration checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_lockout_off: assert property (supply_low_lockout && clk_en |=>
    !coil_drive_a_oe && !coil_drive_b_oe) else $error("drive during supply lockout");
  a_overtemp_off: assert property (overtemp_shutdown && clk_en |=>
    !coil_drive_a_oe && !coil_drive_b_oe) else $error("drive during overtemp");
  a_enable_gate: assert property ($rose(coil_drive_a_oe) || $rose(coil_drive_b_oe)
    |-> $past(en_filt_ff)) else $error("pulse without filtered enable");
  a_enable_filter: assert property ($changed(en_filt_ff) |->
    $past(en_cnt_ff) == `DRC_EN_W'(`DRC_EN_FILT_CYC - 1)) else $error("enable filter bypassed");
  a_never_both: assert property (!(coil_drive_a_oe && coil_drive_b_oe))
    else $error("both coils driven");
  a_qual_start: assert property ($rose(coil_drive_a_oe) |-> $past(qualified[0]))
    else $error("coil a without qualification");
  a_other_discard: assert property (coil_drive_a_oe |-> chan_clr[1])
    else $error("channel b live during pulse a");
  a_max_width: assert property (pulse_cnt_ff <= MAX_TICKS)
    else $error("pulse beyond maximum width");
  a_both_none: assert property (state_ff == ST_IDLE && qualified == 2'h3 && clk_en
    |=> state_ff != ST_PULSE_A && state_ff != ST_PULSE_B) else $error("pulse after both qualified");
  a_rearm_clear: assert property (state_ff == ST_REARM && clk_en |=>
    !qualified[0] && !qualified[1]) else $error("channels not rearmed");
  a_pending_hold: assert property (state_ff == ST_IDLE && qualified[0]
    && qualifying[1] && clk_en |=> state_ff != ST_PULSE_A) else $error("pulse a during b qualify");

  c_pulse_a: cover property ($rose(coil_drive_a_oe));
  c_pulse_b: cover property ($rose(coil_drive_b_oe));
  c_max_end: cover property (in_pulse(state_ff) && pulse_end && sync2_ff != 2'h0);
  c_both_qual: cover property (state_ff == ST_IDLE && qualified == 2'h3);
  c_pend_a: cover property (state_ff == ST_IDLE && qualified[0] && qualifying[1]);
endmodule : drc_top
`default_nettype wire

/* File: inc/drc_regs.svh */
// timing and width constants of the relay pulse controller
`ifndef DRC_REGS_SVH
`define DRC_REGS_SVH
`define DRC_CLK_PERIOD_NS 10
`define DRC_TICK_NS       1000
`define DRC_TICK_CYC      (`DRC_TICK_NS / `DRC_CLK_PERIOD_NS)
`define DRC_EN_FILT_NS    5000
`define DRC_EN_FILT_CYC   (`DRC_EN_FILT_NS / `DRC_CLK_PERIOD_NS)
`define DRC_QUAL_US       15000
`define DRC_MAX_US        150000
`define DRC_US_TO_TICKS(t) ((t) * 1000 / `DRC_TICK_NS)
`define DRC_TICK_W        7
`define DRC_EN_W          10
`define DRC_CNT_W         18
`define DRC_TICK_RST      7'h00
`define DRC_EN_RST        10'h000
`define DRC_CNT_RST       18'h00000
`endif

/* File: inc/drc_pkg.sv */
// types of the relay pulse controller
package drc_pkg;
  typedef enum logic {DRC_MODE_FOLLOW, DRC_MODE_FIXED} drc_mode_type;
  typedef enum logic [1:0] {CH_IDLE, CH_QUAL, CH_DONE, CH_WAIT_LOW} drc_chan_state_type;
  typedef enum logic [1:0] {ST_IDLE, ST_PULSE_A, ST_PULSE_B, ST_REARM} drc_state_type;
endpackage : drc_pkg

/* File: core/drc_chan.sv */
// one command qualification channel
`timescale 1ns/10ps
`default_nettype none
`include "drc_regs.svh"
module drc_chan
  import drc_pkg::*;
#(
  parameter logic [`DRC_CNT_W-1:0] QUAL_TICKS = `DRC_CNT_W'(`DRC_US_TO_TICKS(`DRC_QUAL_US))
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic tick,
  input  wire logic clr,
  input  wire logic cmd,
  output logic      qualifying,
  output logic      qualified
);
  drc_chan_state_type       state_ff;
  drc_chan_state_type       nxt_state;
  logic                     prev_ff;
  logic [`DRC_CNT_W-1:0]    cnt_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CH_IDLE: begin
        if (cmd && !prev_ff) nxt_state = CH_QUAL;
      end
      CH_QUAL: begin
        if (!cmd) nxt_state = CH_IDLE;
        else if (tick && cnt_ff == QUAL_TICKS) nxt_state = CH_DONE;
      end
      CH_DONE: begin
        if (!cmd) nxt_state = CH_IDLE;
      end
      CH_WAIT_LOW: begin
        if (!cmd) nxt_state = CH_IDLE;
      end
      default: nxt_state = CH_WAIT_LOW;
    endcase
    if (clr) nxt_state = CH_WAIT_LOW;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) state_ff <= CH_WAIT_LOW;
    else if (clk_en) state_ff <= nxt_state;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) prev_ff <= 1'b0;
    else if (clk_en) prev_ff <= cmd;
  end

  // qualification time counted in timebase ticks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= `DRC_CNT_RST;
    else if (clk_en) begin
      if (state_ff != CH_QUAL) cnt_ff <= `DRC_CNT_RST;
      else if (tick && cnt_ff != QUAL_TICKS) cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign qualifying = (state_ff == CH_QUAL);
  assign qualified  = (state_ff == CH_DONE);
endmodule : drc_chan
`default_nettype wire

/* File: test/drc_coil_load.sv */
// relay coil load model: pull-up node and pulse width meter
`timescale 1ns/10ps
`default_nettype none
module drc_coil_load (
  input  wire logic mclk,
  input  wire logic drv_oe,
  input  wire logic drv_out,
  output logic      coil_node,
  output var int    pulses,
  output var int    width
);
  int run;
  // coil pulls the node up whenever the switch is released
  assign coil_node = (drv_oe === 1'b1) ? drv_out : 1'b1;
  initial begin
    pulses = 0;
    width  = 0;
    run    = 0;
  end
  always @(posedge mclk) begin
    if (coil_node === 1'b0) begin
      run <= run + 1;
    end else if (run != 0) begin
      pulses <= pulses + 1;
      width  <= run;
      run    <= 0;
    end
  end
endmodule : drc_coil_load
`default_nettype wire

/* File: test/drc_top_tb_top.sv */
// bench of the relay pulse controller, follow and fixed variants side by side
`timescale 1ns/10ps
`default_nettype none
module drc_top_tb_top;
  import drc_pkg::*;
  localparam int QT = 3;
  localparam int MT = 6;
  localparam int QD = (QT + 1) * 100 - 50;
  localparam int MW = MT * 100;
  localparam int NK = 99999;
  logic       mclk        = 1'b0;
  logic       rst_n       = 1'b0;
  logic       cmd_a       = 1'b0;
  logic       cmd_b       = 1'b0;
  logic       en          = 1'b0;
  logic       uv          = 1'b0;
  logic       ot          = 1'b0;
  wire  [3:0] oe;
  wire  [3:0] od;
  wire  [3:0] node;
  int         pulses [4];
  int         width [4];
  int         err_total   = 0;
  int         comparisons = 0;
  int         cyc         = 0;
  always #5 mclk = ~mclk;
  for (genvar g = 0; g < 2; g++) begin : g_dut
    drc_top #(
      .QUAL_TICKS(18'(QT)),
      .MAX_TICKS(18'(MT)),
      .OUT_MODE((g == 1) ? DRC_MODE_FIXED : DRC_MODE_FOLLOW)
    ) i_drc_top (
      .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1),
      .coil_cmd_a(cmd_a), .coil_cmd_b(cmd_b), .relay_enable(en),
      .supply_low_lockout(uv), .overtemp_shutdown(ot),
      .coil_drive_a_out(od[2*g]), .coil_drive_a_oe(oe[2*g]),
      .coil_drive_b_out(od[2*g+1]), .coil_drive_b_oe(oe[2*g+1])
    );
  end
  for (genvar c = 0; c < 4; c++) begin : g_load
    drc_coil_load i_drc_coil_load (
      .mclk(mclk), .drv_oe(oe[c]), .drv_out(od[c]),
      .coil_node(node[c]), .pulses(pulses[c]), .width(width[c])
    );
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 45000) begin
      err_total = err_total + 1;
      end_of_test();
    end
  end
  function automatic int mn(input int x, input int y);
    return (x < y) ? x : y;
  endfunction : mn
  task automatic chk(input string what, input int k, input int exp, input int got, input int tol);
    comparisons++;
    if (got < exp - tol || got > exp + tol) begin
      err_total++;
      $display("MISMATCH %s %0d expected %0d seen %0d", what, k, exp, got);
    end
  endtask : chk
  // la/lb high times, db rise of b; at kt: 1 enable low, 2 supply, 3 temp; 4 held before enable
  task automatic sc(input int la, input int db, input int lb, input int kt, input int kk);
    int l [2];
    int o [2];
    int s [2];
    int q [2];
    int p0 [4];
    int lim;
    int w;
    p0 = pulses;
    l = '{la, lb};
    o = '{0, db};
    s = '{QD, QD};
    q = '{int'(la >= 400 && kk != 4), int'(lb >= 400)};
    if (q[0] && q[1] && db < QD) q = '{0, 0};
    else if (q[0] && db >= QD) q[1] = 0;
    else if (lb > 0 && db < QD) s[0] = (db + lb > QD) ? db + lb : QD;
    lim = (kk == 1) ? kt + 500 : kt + 1;
    if (kk == 4) begin
      en = 1'b0;
      repeat (600) @(negedge mclk);
      cmd_a = 1'b1;
      repeat (100) @(negedge mclk);
      en = 1'b1;
    end
    for (int t = 0; t < 1500; t++) begin
      @(negedge mclk);
      cmd_a = (t < la);
      cmd_b = (t >= db && t < db + lb);
      if (t == kt) begin
        en = (kk != 1);
        uv = (kk == 2);
        ot = (kk == 3);
      end
    end
    @(negedge mclk);
    cmd_a = 1'b0;
    cmd_b = 1'b0;
    en = 1'b1;
    uv = 1'b0;
    ot = 1'b0;
    repeat (699) @(negedge mclk);
    for (int k = 0; k < 4; k++) begin
      w = q[k%2] ? mn((k > 1) ? MW : mn(MW, l[k%2] - s[k%2]), lim - o[k%2] - s[k%2]) : 0;
      w = (w < 0) ? 0 : w;
      chk("pulse count", k, int'(w > 0), pulses[k] - p0[k], 0);
      if (w > 0) chk("pulse width", k, w, width[k], 110);
    end
  endtask : sc
  task automatic end_of_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    void'($urandom(32'h888c));
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    en = 1'b1;
    repeat (600) @(negedge mclk);
    sc(200, 0, 0, NK, 0);
    sc(700, 0, 0, NK, 0);
    sc(1200, 0, 0, NK, 0);
    sc(0, 0, 700, NK, 0);
    sc(900, 100, 350, NK, 0);
    sc(900, 0, 900, NK, 0);
    sc(900, 150, 900, NK, 0);
    sc(1000, 500, 800, NK, 0);
    sc(1000, 0, 0, 100, 1);
    sc(1000, 0, 0, 500, 2);
    sc(1000, 0, 0, 500, 3);
    sc(1500, 0, 0, NK, 4);
    for (int r = 0; r < 4; r++) begin
      sc(600 + $urandom_range(600), 0, 0, NK, 0);
    end
    end_of_test();
  end
endmodule : drc_top_tb_top
`default_nettype wire
